//--- rtl/gcs_pkg.sv
// constants for the global control and status register bank
// Functional notes
// RULE_01 - each internal register location is one 16-bit word
// RULE_02 - internal address is the host address with its lowest bit dropped
// RULE_03 - unimplemented bits ignore writes; their read value is free
// RULE_04 - all bits reset to zero unless another reset value is given
// RULE_05 - host must never write undefined mode codes into mode fields
// RULE_06 - global registers sit at word offsets 0x0 to 0xC in fixed order
// RULE_07 - enable bits 0-3: front-panel input, header removal, crossbar, crossbar RAM
// RULE_08 - enable bits 4-6: buffer arbiter, buffer core, buffer receiver
// RULE_09 - enable bits 7-10: header RAM, delay generator, standard output, station output
// RULE_10 - enable bits 11-14: timing, frame boundary, pattern generator, pattern receiver
// RULE_11 - enable bit 15 is read-only and always reads one
// RULE_12 - status bit 0 latches a frame header error until device reset
// RULE_13 - status bits 1 and 2 show lock of board and divided clocks
// RULE_14 - status bit 3 is set when buffer clock stops; host then resets
// RULE_15 - status bit 8 shows buffer initialisation done, buffer then full
// RULE_16 - status bits 10-9 give buffer occupancy in quarters, 00 to 11
// RULE_17 - status bit 11 is set while the buffer holds no data
// RULE_18 - synthesizer control bits 7-0 drive the synthesizer data lines
// RULE_19 - synthesizer control bit 8 drives the frequency-update strobe
// RULE_20 - synthesizer control bit 9 drives the synthesizer reset line
// RULE_21 - synthesizer control bit 10 drives its control clock, toggled by software
// RULE_22 - status bits 7-4 and 15-12 read zero; status inputs are synchronised
package gcs_pkg;
   // ***********************************
   // address layout
   // ***********************************
   localparam int unsigned HOST_AW = 21;
   localparam int unsigned IDX_W = 20;
   localparam logic [19:0] OFS_ENABLES = 20'h00000;
   localparam logic [19:0] OFS_STATUS = 20'h00001;
   localparam logic [19:0] OFS_SYNTH = 20'h00002;
   localparam logic [19:0] OFS_RESETS_LOW = 20'h00003;
   localparam logic [19:0] OFS_START_HIGH = 20'h00006;
   localparam logic [19:0] OFS_IDENTITY = 20'h00007;
   localparam logic [19:0] OFS_CONTROL = 20'h00009;
   localparam logic [19:0] OFS_MASK = 20'h0000A;
   localparam logic [19:0] OFS_FLAGS = 20'h0000B;
   localparam logic [19:0] OFS_FRAME_CNT = 20'h0000C;
   localparam int unsigned STORE_LO = 3;
   localparam int unsigned STORE_HI = 10;
   // ***********************************
   // reset values
   // ***********************************
   localparam logic [14:0] RST_ENABLES = 15'h0000;
   localparam logic [10:0] RST_SYNTH = 11'h000;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [15:0] RST_CONTROL = 16'h0004;
   // arbitrary value, not a real part code
   localparam logic [15:0] IDENTITY_VALUE = 16'h0000;
   // ***********************************
   // field positions
   // ***********************************
   localparam int unsigned ENB_FIXED_ONE = 15;
   localparam int unsigned ST_HDR_ERR = 0;
   localparam int unsigned ST_LOCK_BOARD = 1;
   localparam int unsigned ST_LOCK_DIV = 2;
   localparam int unsigned ST_CLK_STOP = 3;
   localparam int unsigned ST_INIT_DONE = 8;
   localparam int unsigned ST_FILL_LO = 9;
   localparam int unsigned ST_FILL_HI = 10;
   localparam int unsigned ST_EMPTY = 11;
   localparam int unsigned SYN_DATA_HI = 7;
   localparam int unsigned SYN_FREQ = 8;
   localparam int unsigned SYN_RST = 9;
   localparam int unsigned SYN_CLK = 10;
   localparam logic [31:0] FULL_SAMPLES = 32'h03D08DE0;
   // ***********************************
   // synchroniser
   // ***********************************
   localparam int unsigned STAT_IN_W = 8;
   localparam logic [7:0] RST_STAT = 8'h00;
endpackage : gcs_pkg

//--- rtl/gcs_global_regs.sv
// global control and status register bank of the playback output board
`timescale 1ns/1ns
module gcs_global_regs (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // host register port
   input wire logic [20:0] host_addr,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [15:0] host_wr_data,
   output logic [15:0] host_rd_data,
   output logic host_rd_valid,
   // status inputs from other clock domains
   input wire logic disk_header_error,
   input wire logic board_clock_locked,
   input wire logic divided_clock_locked,
   input wire logic buffer_clock_stopped,
   input wire logic buffer_init_done,
   input wire logic [1:0] buffer_fill_code,
   input wire logic buffer_empty,
   // module enables
   output logic [14:0] module_enable,
   // synthesizer control lines
   output logic [7:0] synth_data_lines,
   output logic synth_freq_strobe,
   output logic synth_reset_line,
   output logic synth_control_clock
);

   // ***********************************
   // address decode
   // ***********************************
   logic [19:0] word_idx;
   logic [10:0] synth_reg;
   logic [15:0] store [gcs_pkg::STORE_LO:gcs_pkg::STORE_HI];
   logic [15:0] status_word;
   logic [15:0] next_rd_data;
   logic hdr_err;
   logic clk_stop;

   // host byte address to word index
   assign word_idx = host_addr[20:1]; // RULE_01 RULE_02

   // ***********************************
   // status synchronisers
   // ***********************************
   logic [7:0] stat_raw;
   logic [7:0] sync1;
   logic [7:0] sync2;
   logic [7:0] sync3;
   logic [7:0] stat;

   assign stat_raw = {buffer_empty, buffer_fill_code, buffer_init_done,
                      buffer_clock_stopped, divided_clock_locked,
                      board_clock_locked, disk_header_error};

   // three stages; a change counts once stages two and three agree
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1 <= gcs_pkg::RST_STAT;
         sync2 <= gcs_pkg::RST_STAT;
         sync3 <= gcs_pkg::RST_STAT;
      end else begin
         sync1 <= stat_raw; // RULE_22
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // per-bit agreement filter; fill code bits may settle a cycle apart
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         stat <= gcs_pkg::RST_STAT;
      end else begin
         for (int i = 0; i < gcs_pkg::STAT_IN_W; i++) begin
            if (sync2[i] == sync3[i]) begin
               stat[i] <= sync3[i]; // RULE_22
            end
         end
      end
   end

   // ***********************************
   // sticky status
   // ***********************************
   // only a full device reset clears these
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         hdr_err <= 1'b0;
      end else if (stat[0]) begin
         hdr_err <= 1'b1; // RULE_12
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         clk_stop <= 1'b0;
      end else if (stat[3]) begin
         clk_stop <= 1'b1; // RULE_14
      end
   end

   always_comb begin
      status_word = 16'h0000; // RULE_22
      status_word[gcs_pkg::ST_HDR_ERR] = hdr_err; // RULE_12
      status_word[gcs_pkg::ST_LOCK_BOARD] = stat[1]; // RULE_13
      status_word[gcs_pkg::ST_LOCK_DIV] = stat[2]; // RULE_13
      status_word[gcs_pkg::ST_CLK_STOP] = clk_stop; // RULE_14
      status_word[gcs_pkg::ST_INIT_DONE] = stat[4]; // RULE_15
      status_word[gcs_pkg::ST_FILL_HI:gcs_pkg::ST_FILL_LO] = stat[6:5]; // RULE_16
      status_word[gcs_pkg::ST_EMPTY] = stat[7]; // RULE_17
   end

   // ***********************************
   // writable registers
   // ***********************************
   // bit 15 has no storage, so writes to it are lost
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         module_enable <= gcs_pkg::RST_ENABLES; // RULE_04
      end else if (host_wr && word_idx == gcs_pkg::OFS_ENABLES) begin
         module_enable <= host_wr_data[14:0]; // RULE_07 RULE_08 RULE_09 RULE_10 RULE_11
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         synth_reg <= gcs_pkg::RST_SYNTH; // RULE_04
      end else if (host_wr && word_idx == gcs_pkg::OFS_SYNTH) begin
         synth_reg <= host_wr_data[10:0]; // RULE_03
      end
   end

   // synthesizer lines are bit-banged; no timing is enforced here
   assign synth_data_lines = synth_reg[gcs_pkg::SYN_DATA_HI:0]; // RULE_18
   assign synth_freq_strobe = synth_reg[gcs_pkg::SYN_FREQ]; // RULE_19
   assign synth_reset_line = synth_reg[gcs_pkg::SYN_RST]; // RULE_20
   assign synth_control_clock = synth_reg[gcs_pkg::SYN_CLK]; // RULE_21

   // plain storage for words whose fields belong to other blocks
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = gcs_pkg::STORE_LO; i <= gcs_pkg::STORE_HI; i++) begin
            store[i] <= gcs_pkg::RST_WORD; // RULE_04
         end
         store[gcs_pkg::OFS_CONTROL] <= gcs_pkg::RST_CONTROL;
      end else if (host_wr) begin
         for (int i = gcs_pkg::STORE_LO; i <= gcs_pkg::STORE_HI; i++) begin
            if (word_idx == 20'(i) && word_idx != gcs_pkg::OFS_IDENTITY) begin
               store[i] <= host_wr_data; // RULE_06
            end
         end
      end
   end

   // ***********************************
   // read path
   // ***********************************
   always_comb begin
      next_rd_data = 16'h0000;
      if (word_idx == gcs_pkg::OFS_ENABLES) begin
         next_rd_data = {1'b1, module_enable}; // RULE_11
      end else if (word_idx == gcs_pkg::OFS_STATUS) begin
         next_rd_data = status_word;
      end else if (word_idx == gcs_pkg::OFS_SYNTH) begin
         next_rd_data = {5'h00, synth_reg}; // RULE_03
      end else if (word_idx == gcs_pkg::OFS_IDENTITY) begin
         next_rd_data = gcs_pkg::IDENTITY_VALUE;
      end else if (word_idx >= gcs_pkg::OFS_RESETS_LOW && word_idx <= gcs_pkg::OFS_MASK) begin
         next_rd_data = store[word_idx[3:0]]; // RULE_06
      end
      // flags, frame counter and unmapped words read zero
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         host_rd_data <= 16'h0000;
      end else if (host_rd) begin
         host_rd_data <= next_rd_data;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         host_rd_valid <= 1'b0;
      end else begin
         host_rd_valid <= host_rd;
      end
   end

   // ***********************************
   // assertions
   // ***********************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   enable_write_a: assert property (host_wr && word_idx == gcs_pkg::OFS_ENABLES |=> // RULE_07
      module_enable == $past(host_wr_data[14:0]))
      else $error("enable register did not take written value");

   fixed_one_a: assert property (host_rd && word_idx == gcs_pkg::OFS_ENABLES |=> // RULE_11
      host_rd_data[15] && host_rd_valid)
      else $error("enable bit 15 did not read one");

   hdr_sticky_a: assert property (hdr_err |=> hdr_err) // RULE_12
      else $error("header error flag cleared without reset");

   hdr_set_a: assert property ($rose(stat_raw[0]) ##3 stat_raw[0] |=> ##[0:2] hdr_err) // RULE_12
      else $error("header error not latched");

   zero_bits_a: assert property (host_rd && word_idx == gcs_pkg::OFS_STATUS |=> // RULE_22
      host_rd_data[7:4] == 4'h0 && host_rd_data[15:12] == 4'h0)
      else $error("reserved status bits not zero");

   lock_read_a: assert property (host_rd && word_idx == gcs_pkg::OFS_STATUS |=> // RULE_13
      host_rd_data[2:1] == $past(stat[2:1]))
      else $error("lock bits wrong on status read");

   fill_read_a: assert property (host_rd && word_idx == gcs_pkg::OFS_STATUS |=> // RULE_16
      host_rd_data[10:9] == $past(stat[6:5]) && host_rd_data[11] == $past(stat[7]))
      else $error("fill or empty bits wrong on status read");

   stop_sticky_a: assert property (stat[3] |=> clk_stop ##1 clk_stop) // RULE_14
      else $error("clock stop flag not held");

   synth_write_a: assert property (host_wr && word_idx == gcs_pkg::OFS_SYNTH |=> // RULE_21
      {synth_control_clock, synth_reset_line, synth_freq_strobe, synth_data_lines}
      == $past(host_wr_data[10:0]))
      else $error("synthesizer lines did not follow write");

   lsb_drop_a: assert property (host_wr && host_addr[20:1] == gcs_pkg::OFS_SYNTH && host_addr[0] |=> // RULE_02
      synth_data_lines == $past(host_wr_data[7:0]))
      else $error("address low bit not ignored");

   enable_buffer_a: assert property (host_wr && word_idx == gcs_pkg::OFS_ENABLES |=> // RULE_08
      module_enable[6:4] == $past(host_wr_data[6:4]))
      else $error("buffer enables did not take written value");

   enable_output_a: assert property (host_wr && word_idx == gcs_pkg::OFS_ENABLES |=> // RULE_09
      module_enable[10:7] == $past(host_wr_data[10:7]))
      else $error("output enables did not take written value");

   enable_test_a: assert property (host_wr && word_idx == gcs_pkg::OFS_ENABLES |=> // RULE_10
      module_enable[14:11] == $past(host_wr_data[14:11]))
      else $error("timing and test enables did not take written value");

   enable_hold_a: assert property (!(host_wr && word_idx == gcs_pkg::OFS_ENABLES) |=> // RULE_07
      $stable(module_enable))
      else $error("enables changed without a write");

   synth_hold_a: assert property (!(host_wr && word_idx == gcs_pkg::OFS_SYNTH) |=> // RULE_20
      $stable({synth_reset_line, synth_freq_strobe, synth_control_clock, synth_data_lines}))
      else $error("synthesizer lines changed without a write");

   // ***********************************
   // read path assertions
   // ***********************************
   // valid and data are both judged one cycle after the strobe
   rd_valid_a: assert property (host_rd_valid == $past(host_rd)) // RULE_06
      else $error("read valid not one cycle after strobe");

   rd_hold_a: assert property (!$past(host_rd) |-> $stable(host_rd_data)) // RULE_06
      else $error("read data changed without a read");

   identity_read_a: assert property (host_rd && word_idx == gcs_pkg::OFS_IDENTITY |=> // RULE_06
      host_rd_data == gcs_pkg::IDENTITY_VALUE)
      else $error("identity word read wrong");

   high_read_a: assert property (host_rd && word_idx > gcs_pkg::OFS_MASK |=> // RULE_03
      host_rd_data == 16'h0000)
      else $error("flags, counter or unmapped word not zero");

   synth_upper_a: assert property (host_rd && word_idx == gcs_pkg::OFS_SYNTH |=> // RULE_03
      host_rd_data[15:11] == 5'h00)
      else $error("unused synthesizer bits not zero");

   init_read_a: assert property (host_rd && word_idx == gcs_pkg::OFS_STATUS |=> // RULE_15
      host_rd_data[8] == $past(stat[4]))
      else $error("init done bit wrong on status read");

   // write, one idle cycle, then a read of the same word
   store_rw_a: assert property (host_wr && word_idx != gcs_pkg::OFS_IDENTITY // RULE_06
      && word_idx >= gcs_pkg::OFS_RESETS_LOW && word_idx <= gcs_pkg::OFS_MASK
      ##1 !host_wr ##1 host_rd && word_idx == $past(word_idx, 2)
      |=> host_rd_data == $past(host_wr_data, 3))
      else $error("stored word did not read back");

   enable_cov: cover property (host_wr && word_idx == gcs_pkg::OFS_ENABLES ##1 host_rd);
   status_cov: cover property (hdr_err && clk_stop && host_rd && word_idx == gcs_pkg::OFS_STATUS);
   synth_cov: cover property (synth_control_clock ##1 !synth_control_clock);
   store_cov: cover property (host_wr && word_idx == gcs_pkg::OFS_CONTROL);
   unmapped_cov: cover property (host_rd && word_idx > gcs_pkg::OFS_FRAME_CNT);

endmodule : gcs_global_regs

//--- tb/gcs_host_model.sv
// host-side model that drives the word-wide register port
`timescale 1ns/1ns
module gcs_host_model (
   // clock
   input wire logic ref_clk,
   // register port
   output logic [20:0] host_addr,
   output logic host_wr,
   output logic host_rd,
   output logic [15:0] host_wr_data,
   input wire logic [15:0] host_rd_data,
   input wire logic host_rd_valid
);
   initial begin
      host_addr = 21'h000000;
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_wr_data = 16'h0000;
   end
   // byte address is twice the word index; the low bit carries junk on purpose
   task automatic wr(input logic [19:0] idx, input logic [15:0] d, input logic b0);
      @(posedge ref_clk);
      host_addr <= {idx, b0};
      host_wr <= 1'b1;
      host_wr_data <= d;
      @(posedge ref_clk);
      host_wr <= 1'b0;
      host_wr_data <= ~d;
   endtask : wr
   task automatic rd(input logic [19:0] idx, input logic b0, output logic [15:0] q);
      int n;
      @(posedge ref_clk);
      host_addr <= {idx, b0};
      host_rd <= 1'b1;
      @(posedge ref_clk);
      host_rd <= 1'b0;
      host_addr <= ~{idx, b0};
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (host_rd_valid !== 1'b1 && n < 4);
      // valid late or missing: hand back a word that cannot match
      q = (n == 1 && host_rd_valid === 1'b1) ? host_rd_data : ~host_rd_data;
   endtask : rd
endmodule : gcs_host_model

//--- tb/global_control_status_regs_tb.sv
// self-checking bench for the global control and status register bank
`timescale 1ns/1ns
module global_control_status_regs_tb;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic disk_header_error = 1'b0;
   logic board_clock_locked = 1'b0;
   logic divided_clock_locked = 1'b0;
   logic buffer_clock_stopped = 1'b0;
   logic buffer_init_done = 1'b0;
   logic [1:0] buffer_fill_code = 2'h0;
   logic buffer_empty = 1'b0;
   logic [20:0] host_addr;
   logic host_wr, host_rd, host_rd_valid, synth_freq_strobe, synth_reset_line, synth_control_clock;
   logic [15:0] host_wr_data, host_rd_data;
   logic [14:0] module_enable;
   logic [7:0] synth_data_lines;
   logic [15:0] shadow [0:15];
   logic [15:0] synth_word;
   logic st_hdr, st_stop;
   logic [31:0] rnd = 32'h53245E4F;
   int failures = 0;
   int n_tests = 0;
   always #4 ref_clk = ~ref_clk;
   assign synth_word = {5'h00, synth_control_clock, synth_reset_line, synth_freq_strobe, synth_data_lines};
   gcs_global_regs u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .host_addr(host_addr), .host_wr(host_wr),
      .host_rd(host_rd), .host_wr_data(host_wr_data), .host_rd_data(host_rd_data), .host_rd_valid(host_rd_valid),
      .disk_header_error(disk_header_error), .board_clock_locked(board_clock_locked),
      .divided_clock_locked(divided_clock_locked), .buffer_clock_stopped(buffer_clock_stopped),
      .buffer_init_done(buffer_init_done), .buffer_fill_code(buffer_fill_code), .buffer_empty(buffer_empty),
      .module_enable(module_enable), .synth_data_lines(synth_data_lines), .synth_freq_strobe(synth_freq_strobe),
      .synth_reset_line(synth_reset_line), .synth_control_clock(synth_control_clock));
   gcs_host_model u_host (.ref_clk(ref_clk), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
      .host_wr_data(host_wr_data), .host_rd_data(host_rd_data), .host_rd_valid(host_rd_valid));
   // ***********************************
   // expectation helpers
   // ***********************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction : lfsr
   function automatic logic [15:0] exp_word(input logic [3:0] i);
      case (i)
         4'h0: return {1'b1, shadow[0][14:0]};
         4'h1: return {4'h0, buffer_empty, buffer_fill_code, buffer_init_done, 4'h0, st_stop,
            divided_clock_locked, board_clock_locked, st_hdr};
         4'h2: return {5'h00, shadow[2][10:0]};
         4'h7: return gcs_pkg::IDENTITY_VALUE;
         4'hB, 4'hC, 4'hD, 4'hE, 4'hF: return 16'h0000;
         default: return shadow[i];
      endcase
   endfunction : exp_word
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      n_tests++;
      if (seen !== want) begin
         failures++;
         $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check
   task automatic clear_model();
      foreach (shadow[i]) shadow[i] = 16'h0000;
      shadow[9] = gcs_pkg::RST_CONTROL;
      st_hdr = 1'b0;
      st_stop = 1'b0;
   endtask : clear_model
   task automatic sweep(input string name);
      logic [15:0] q;
      for (int k = 0; k < 13; k++) begin
         u_host.rd(20'(k), 1'b0, q);
         check(q, exp_word(4'(k)));
      end
      check({1'b0, module_enable}, {1'b0, shadow[0][14:0]});
      check(synth_word, {5'h00, shadow[2][10:0]});
      $display("test %s done", name);
   endtask : sweep
   task automatic finish_test();
      $display("compares %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test
   // ***********************************
   // test sequence
   // ***********************************
   initial begin
      logic [15:0] q;
      logic [3:0] idx;
      clear_model();
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      sweep("reset_values");
      for (int k = 0; k < 40; k++) begin
         rnd = lfsr(rnd);
         idx = (rnd[31:28] > 4'hC) ? 4'h2 : rnd[31:28];
         u_host.wr({16'h0000, idx}, rnd[15:0], rnd[16]);
         if (idx inside {4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA}) shadow[idx] = rnd[15:0];
         u_host.rd({16'h0000, idx}, rnd[17], q);
         check(q, exp_word(idx));
         check({1'b0, module_enable}, {1'b0, shadow[0][14:0]});
         check(synth_word, {5'h00, shadow[2][10:0]});
      end
      // software bit-bangs the control clock: one rise, one fall
      u_host.wr(20'h00002, 16'h0400, 1'b1);
      @(posedge ref_clk);
      check(synth_word, 16'h0400);
      u_host.wr(20'h00002, 16'h0000, 1'b0);
      @(posedge ref_clk);
      check(synth_word, 16'h0000);
      shadow[2] = 16'h0000;
      $display("test random_access done");
      u_host.wr(20'h01000, 16'hFFFF, 1'b0);
      u_host.rd(20'h01000, 1'b1, q);
      check(q, 16'h0000);
      sweep("unmapped_write");
      for (int k = 0; k < 12; k++) begin
         rnd = lfsr(rnd);
         @(posedge ref_clk);
         disk_header_error <= (k == 3) | (rnd[0] & rnd[1]);
         board_clock_locked <= rnd[2];
         divided_clock_locked <= rnd[3];
         buffer_clock_stopped <= (k == 7) | (rnd[4] & rnd[5] & rnd[6]);
         buffer_init_done <= rnd[7];
         buffer_fill_code <= rnd[9:8];
         buffer_empty <= rnd[10];
         st_hdr = st_hdr | (k == 3) | (rnd[0] & rnd[1]);
         st_stop = st_stop | (k == 7) | (rnd[4] & rnd[5] & rnd[6]);
         repeat (6) @(posedge ref_clk);
         u_host.rd(20'h00001, rnd[11], q);
         check(q, exp_word(4'h1));
      end
      $display("test status done");
      // host answers a stopped buffer clock with a device reset
      @(posedge ref_clk);
      reset_n <= 1'b0;
      {disk_header_error, board_clock_locked, divided_clock_locked, buffer_clock_stopped} <= 4'h0;
      {buffer_init_done, buffer_fill_code, buffer_empty} <= 4'h0;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      clear_model();
      sweep("second_reset");
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      $display("watchdog expired");
      finish_test();
   end
endmodule : global_control_status_regs_tb
